/* File: verilog/fllcc_top.sv */
/*
 * Clock mode controller: APB byte registers, mode decode, glitch-free source
 * switching, bus divider, FLL reference divider and relock, gated references.
 * Assumes all clock-like inputs are synchronous levels sampled on clk_i,
 * each well below half the clk_i rate; the analog parts live outside.
 */
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "fllcc_defs.svh"

module fllcc_top
    import fllcc_pkg::*;
#(
    parameter logic [7:0] TRIM_INIT = `FLLCC_TRIM_RST
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        int_ref_i,
    input  wire logic        ext_ref_i,
    input  wire logic        fll_clk_i,
    input  wire logic        osc_init_done_i,
    input  wire logic        stop_i,
    input  wire logic        debug_mode_active_i,
    output logic             system_clock_out_o,
    output logic             bus_clock_o,
    output logic             debug_link_clock_o,
    output logic             gated_internal_reference_o,
    output logic             gated_external_reference_o,
    output logic             fll_enable_o,
    output logic             fll_reference_select_o,
    output logic             fll_filter_clock_o,
    output logic [9:0]       fll_multiplier_o,
    output logic             fll_relock_o,
    output logic             int_ref_enable_o,
    output logic             ext_ref_enable_o,
    output logic             osc_range_o,
    output logic             osc_high_gain_o,
    output logic [7:0]       coarse_trim_o,
    output logic             fine_trim_o,
    output fllcc_mode_t      clock_mode_o
);

    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] trim_q = TRIM_INIT;   // Power-up value only, no reset
    logic       fine_q = 1'b0;        // Power-up value only, no reset
    logic       osc_ready_q;
    fllcc_src_t active_src_q;
    logic [1:0] pend_src_q;
    logic [2:0] sw_cnt_q;
    logic       sys_q;
    logic       int_q, ext_q, fll_q, filt_q;
    logic [2:0] bus_cnt_q;
    logic [6:0] ref_cnt_q;
    logic       refsel_q;
    logic       relock_busy_q;
    logic [2:0] relock_cnt_q;
    logic       relock_q;
    logic       lnk_q, gir_q, ger_q, bus_q;
    logic [31:0] prdata_q;

    logic       wr_en, rd_phase, hit;
    logic [7:0] wbyte;
    logic [1:0] src_req;
    logic       lp_active, fll_on;
    logic       src_lvl, pend_lvl, pend_rise;
    logic       ref_lvl, filt_lvl, filt_rise, sys_rise;
    fllcc_mode_t mode;

    // APB decode; always ready, unmapped addresses answer with an error
    always_comb begin
        hit = 1'b1;
        if (paddr_i == `FLLCC_CTRL1_OFS) begin
            hit = 1'b1;
        end else if (paddr_i == `FLLCC_CTRL2_OFS) begin
            hit = 1'b1;
        end else if (paddr_i == `FLLCC_TRIM_OFS) begin
            hit = 1'b1;
        end else if (paddr_i == `FLLCC_STATUS_OFS) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign wr_en     = psel_i & penable_i & pwrite_i & hit & pstrb_i[0];
    assign rd_phase  = psel_i & ~penable_i & ~pwrite_i;
    assign wbyte     = pwdata_i[7:0];

    // Control registers; reset gives internal engaged, bus divide by 2
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl1_q <= `FLLCC_CTRL1_RST;
            ctrl2_q <= `FLLCC_CTRL2_RST;
        end else if (wr_en && paddr_i == `FLLCC_CTRL1_OFS) begin
            ctrl1_q <= wbyte;
        end else if (wr_en && paddr_i == `FLLCC_CTRL2_OFS) begin
            ctrl2_q <= wbyte;
        end
    end

    // Trim survives every reset, so it sits outside the reset tree
    always_ff @(posedge clk_i) begin
        if (wr_en && paddr_i == `FLLCC_TRIM_OFS) begin
            trim_q <= wbyte;
        end
        if (wr_en && paddr_i == `FLLCC_STATUS_OFS) begin
            fine_q <= wbyte[`FLLCC_FINE_BIT];
        end
    end
    assign coarse_trim_o = trim_q;   // Larger value, longer period
    assign fine_trim_o   = fine_q;   // Set lengthens by one step

    // Read data captured in the setup phase; status bits 7:4 read zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_q <= 32'h0;
        end else if (rd_phase) begin
            if (paddr_i == `FLLCC_CTRL1_OFS) begin
                prdata_q <= {24'h0, ctrl1_q};
            end else if (paddr_i == `FLLCC_CTRL2_OFS) begin
                prdata_q <= {24'h0, ctrl2_q};
            end else if (paddr_i == `FLLCC_TRIM_OFS) begin
                prdata_q <= {24'h0, trim_q};
            end else if (paddr_i == `FLLCC_STATUS_OFS) begin
                prdata_q <= {28'h0, active_src_q, osc_ready_q, fine_q};
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end
    assign prdata_o = prdata_q;

    // Mode decode; code 11 behaves as FLL output
    assign src_req   = (ctrl1_q[`FLLCC_SRC_MSB:`FLLCC_SRC_LSB] == 2'h3) ? 2'h0
                     : ctrl1_q[`FLLCC_SRC_MSB:`FLLCC_SRC_LSB];
    assign lp_active = ctrl2_q[`FLLCC_LP_BIT] & ~debug_mode_active_i;
    assign fll_on    = ~stop_i & ~((src_req != 2'h0) & lp_active);
    always_comb begin
        if (stop_i) begin
            mode = FLLCC_MODE_STOP;
        end else if (src_req == 2'h0) begin
            mode = ctrl1_q[`FLLCC_REFSEL_BIT] ? FLLCC_MODE_INT_ENGAGED
                                              : FLLCC_MODE_EXT_ENGAGED;
        end else if (src_req == 2'h1) begin
            mode = lp_active ? FLLCC_MODE_INT_BYPASS_LP : FLLCC_MODE_INT_BYPASS;
        end else begin
            mode = lp_active ? FLLCC_MODE_EXT_BYPASS_LP : FLLCC_MODE_EXT_BYPASS;
        end
    end
    assign clock_mode_o           = mode;
    assign fll_enable_o           = fll_on;
    assign fll_reference_select_o = ctrl1_q[`FLLCC_REFSEL_BIT];
    assign fll_multiplier_o       = `FLLCC_FLL_MULT;
    assign osc_range_o            = ctrl2_q[`FLLCC_RANGE_BIT];
    assign osc_high_gain_o        = ctrl2_q[`FLLCC_GAIN_BIT];
    // Reference enables follow the mode so the clock in use always runs
    assign int_ref_enable_o = (ctrl1_q[`FLLCC_IREN_BIT] & (~stop_i | ctrl1_q[`FLLCC_ISTOP_BIT]))
                            | (~stop_i & ctrl1_q[`FLLCC_REFSEL_BIT]) | (~stop_i & src_req == 2'h1);
    assign ext_ref_enable_o = (ctrl2_q[`FLLCC_EREN_BIT] & (~stop_i | ctrl2_q[`FLLCC_ESTOP_BIT]))
                            | (~stop_i & ~ctrl1_q[`FLLCC_REFSEL_BIT])
                            | (~stop_i & src_req == 2'h2);

    // Oscillator ready; a set in the clearing cycle wins
    logic osc_set, osc_clr;
    assign osc_set = osc_init_done_i & ctrl2_q[`FLLCC_OSCSEL_BIT]
                   & (ctrl2_q[`FLLCC_EREN_BIT] | mode == FLLCC_MODE_EXT_ENGAGED
                      | mode == FLLCC_MODE_EXT_BYPASS | mode == FLLCC_MODE_EXT_BYPASS_LP);
    assign osc_clr = wr_en && paddr_i == `FLLCC_CTRL2_OFS
                   && ((ctrl2_q[`FLLCC_EREN_BIT] && !wbyte[`FLLCC_EREN_BIT])
                       || (ctrl2_q[`FLLCC_OSCSEL_BIT] && !wbyte[`FLLCC_OSCSEL_BIT]));
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_ready_q <= 1'b0;
        end else if (osc_set) begin
            osc_ready_q <= 1'b1;
        end else if (osc_clr) begin
            osc_ready_q <= 1'b0;
        end
    end

    // Previous samples of the clock inputs for edge detection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_q <= 1'b0;
            ext_q <= 1'b0;
            fll_q <= 1'b0;
        end else begin
            int_q <= int_ref_i;
            ext_q <= ext_ref_i;
            fll_q <= fll_clk_i & fll_on;
        end
    end

    function automatic logic src_level(input logic [1:0] s, input logic fi, input logic ii,
                                       input logic ei);
        logic r;
        r = (s == 2'h1) ? ii : (s == 2'h2) ? ei : fi;
        return r;
    endfunction

    assign src_lvl   = src_level(active_src_q, fll_clk_i & fll_on, int_ref_i, ext_ref_i);
    assign pend_lvl  = src_level(src_req, fll_clk_i & fll_on, int_ref_i, ext_ref_i);
    assign pend_rise = pend_lvl & ~src_level(src_req, fll_q, int_q, ext_q);

    // Source switch: count new-clock edges, then change while both are low.
    // A dead new clock never reaches the count, so the old one stays.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_src_q <= FLLCC_SRC_FLL;
            pend_src_q   <= 2'h0;
            sw_cnt_q     <= 3'h0;
        end else if (src_req != pend_src_q) begin
            pend_src_q <= src_req;
            sw_cnt_q   <= 3'h0;
        end else if (src_req != 2'(active_src_q)) begin
            if (sw_cnt_q != `FLLCC_SWITCH_EDGES) begin
                sw_cnt_q <= sw_cnt_q + 3'(pend_rise);
            end else if (!pend_lvl && !sys_q) begin
                active_src_q <= fllcc_src_t'(src_req);
                sw_cnt_q     <= 3'h0;
            end
        end
    end

    // System clock held low in stop
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_q <= 1'b0;
        end else begin
            sys_q <= src_lvl & ~stop_i;
        end
    end
    assign system_clock_out_o = sys_q;
    assign sys_rise = src_lvl & ~stop_i & ~sys_q;

    // Bus divider: taps of a free edge counter, so a new code acts at once
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_cnt_q <= 3'h0;
            bus_q     <= 1'b0;
        end else begin
            if (sys_rise) begin
                bus_cnt_q <= bus_cnt_q + 3'h1;
            end
            case (ctrl2_q[`FLLCC_BUS_DIVIDER_MSB:`FLLCC_BUS_DIVIDER_LSB])
                2'h0: bus_q <= src_lvl & ~stop_i;
                2'h1: bus_q <= bus_cnt_q[0];
                2'h2: bus_q <= bus_cnt_q[1];
                default: bus_q <= bus_cnt_q[2];
            endcase
        end
    end
    assign bus_clock_o = bus_q;

    // Reference divider by two to the code, feeding the FLL filter
    assign ref_lvl  = ctrl1_q[`FLLCC_REFSEL_BIT] ? int_ref_i : ext_ref_i;
    assign filt_lvl = (ctrl1_q[`FLLCC_REFERENCE_DIVIDER_MSB:`FLLCC_REFERENCE_DIVIDER_LSB] == 3'h0) ? ref_lvl
                    : ref_cnt_q[3'(ctrl1_q[`FLLCC_REFERENCE_DIVIDER_MSB:`FLLCC_REFERENCE_DIVIDER_LSB] - 3'h1)];
    assign filt_rise = filt_lvl & ~filt_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_cnt_q <= 7'h0;
            filt_q    <= 1'b0;
        end else begin
            if (ref_lvl && !(ctrl1_q[`FLLCC_REFSEL_BIT] ? int_q : ext_q)) begin
                ref_cnt_q <= ref_cnt_q + 7'h1;
            end
            filt_q <= filt_lvl;
        end
    end
    assign fll_filter_clock_o = filt_q;   // FLL locks to 512x this

    // Relock after a reference select change and a few divided cycles
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            refsel_q      <= 1'b1;
            relock_busy_q <= 1'b0;
            relock_cnt_q  <= 3'h0;
            relock_q      <= 1'b0;
        end else begin
            refsel_q <= ctrl1_q[`FLLCC_REFSEL_BIT];
            relock_q <= 1'b0;
            if (refsel_q != ctrl1_q[`FLLCC_REFSEL_BIT]) begin
                relock_busy_q <= 1'b1;
                relock_cnt_q  <= 3'h0;
            end else if (relock_busy_q && filt_rise) begin
                if (relock_cnt_q == `FLLCC_RELOCK_EDGES - 3'h1) begin
                    relock_busy_q <= 1'b0;
                    relock_q      <= 1'b1;
                end else begin
                    relock_cnt_q <= relock_cnt_q + 3'h1;
                end
            end
        end
    end
    assign fll_relock_o = relock_q;

    // Link clock and gated references; stop freezes all but references with both enable and stop enable set
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lnk_q <= 1'b0;
            gir_q <= 1'b0;
            ger_q <= 1'b0;
        end else begin
            lnk_q <= fll_clk_i & fll_on;
            gir_q <= int_ref_i & ctrl1_q[`FLLCC_IREN_BIT]
                   & (~stop_i | ctrl1_q[`FLLCC_ISTOP_BIT]);
            ger_q <= ext_ref_i & ctrl2_q[`FLLCC_EREN_BIT]
                   & (~stop_i | ctrl2_q[`FLLCC_ESTOP_BIT]);
        end
    end
    assign debug_link_clock_o         = lnk_q;
    assign gated_internal_reference_o = gir_q;
    assign gated_external_reference_o = ger_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_src_write;
        src_req != 2'(active_src_q) && sw_cnt_q == 3'h0 && src_req == pend_src_q;
    endsequence
    sequence s_switch_done;
        active_src_q == fllcc_src_t'($past(src_req));
    endsequence

    a_mode_status_sync: assert property (
        $changed(src_req) |=> active_src_q == $past(active_src_q))
        else $error("mode status changed without synchronisation");
    a_switch_dead_clock: assert property (
        s_src_write ##0 (!pend_rise [*4]) |-> src_req == 2'(active_src_q) || sw_cnt_q == 3'h0)
        else $error("switched without edges of the new clock");
    a_switch_glitchless: assert property (
        $changed(active_src_q) |-> !$past(sys_q) && !$past(pend_lvl))
        else $error("source switched while clock high");
    a_osc_ready_set: assert property (
        osc_set |=> osc_ready_q)
        else $error("oscillator ready failed to set");
    a_osc_ready_hold: assert property (
        $fell(osc_ready_q) |-> $past(osc_clr) && !$past(osc_set))
        else $error("oscillator ready cleared by another event");
    a_stop_static: assert property (
        stop_i [*2] |-> !sys_q && !lnk_q && !(gir_q && !$past(ctrl1_q[`FLLCC_ISTOP_BIT])))
        else $error("clock active in stop");
    a_stop_ext_ref: assert property (
        stop_i && ext_ref_i && ctrl2_q[`FLLCC_EREN_BIT] && ctrl2_q[`FLLCC_ESTOP_BIT] |=> ger_q)
        else $error("external reference not kept in stop");
    a_lp_link_off: assert property (
        mode == FLLCC_MODE_INT_BYPASS_LP |-> !fll_enable_o ##1 !lnk_q || mode != $past(mode))
        else $error("link clock in low power bypass");
    a_relock_after: assert property (
        $changed(ctrl1_q[`FLLCC_REFSEL_BIT]) |-> ##[1:2] relock_busy_q)
        else $error("relock not started");
    a_engaged_fll: assert property (
        mode == FLLCC_MODE_INT_ENGAGED |-> fll_enable_o && int_ref_enable_o)
        else $error("internal engaged without FLL");
    a_unmapped_err: assert property (
        psel_i && penable_i && !hit |-> pslverr_o)
        else $error("unmapped access without error");

endmodule // fllcc_top

/* File: verilog/fllcc_defs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * clock mode controller. Assumes byte-wide registers on word-aligned APB addresses.
 */
`ifndef FLLCC_DEFS_SVH
`define FLLCC_DEFS_SVH

`define FLLCC_CTRL1_OFS        12'h000
`define FLLCC_CTRL2_OFS        12'h004
`define FLLCC_TRIM_OFS         12'h008
`define FLLCC_STATUS_OFS       12'h00c

`define FLLCC_CTRL1_RST        8'h04
`define FLLCC_CTRL2_RST        8'h40
`define FLLCC_TRIM_RST         8'h80

`define FLLCC_SRC_MSB          7
`define FLLCC_SRC_LSB          6
`define FLLCC_REFERENCE_DIVIDER_MSB         5
`define FLLCC_REFERENCE_DIVIDER_LSB         3
`define FLLCC_REFSEL_BIT       2
`define FLLCC_IREN_BIT         1
`define FLLCC_ISTOP_BIT        0

`define FLLCC_BUS_DIVIDER_MSB         7
`define FLLCC_BUS_DIVIDER_LSB         6
`define FLLCC_RANGE_BIT        5
`define FLLCC_GAIN_BIT         4
`define FLLCC_LP_BIT           3
`define FLLCC_OSCSEL_BIT       2
`define FLLCC_EREN_BIT         1
`define FLLCC_ESTOP_BIT        0

`define FLLCC_MODE_MSB         3
`define FLLCC_MODE_LSB         2
`define FLLCC_OSCRDY_BIT       1
`define FLLCC_FINE_BIT         0

`define FLLCC_FLL_MULT         10'd512
`define FLLCC_SWITCH_EDGES     3'd3
`define FLLCC_RELOCK_EDGES     3'd3

`endif

/* File: verilog/fllcc_pkg.sv */
/*
 * Types of the clock mode controller: source encodings and clock modes.
 * Assumes the constants header is included by the modules that need it.
 */
package fllcc_pkg;

    // Source select and mode status share this encoding
    typedef enum logic [1:0] {
        FLLCC_SRC_FLL = 2'h0,
        FLLCC_SRC_INT = 2'h1,
        FLLCC_SRC_EXT = 2'h2
    } fllcc_src_t;

    // Seven clock modes, Gray coded along the usual path
    typedef enum logic [2:0] {
        FLLCC_MODE_INT_ENGAGED   = 3'h0,
        FLLCC_MODE_INT_BYPASS    = 3'h1,
        FLLCC_MODE_INT_BYPASS_LP = 3'h3,
        FLLCC_MODE_EXT_ENGAGED   = 3'h2,
        FLLCC_MODE_EXT_BYPASS    = 3'h6,
        FLLCC_MODE_EXT_BYPASS_LP = 3'h7,
        FLLCC_MODE_STOP          = 3'h5
    } fllcc_mode_t;

endpackage

/* File: tb/tb.sv */
/* Self-checking bench of the clock mode controller: APB access, modes, trim, stop.
   Assumes fllcc_pkg is compiled first and fllcc_defs.svh is on the include path. */
`timescale 1ns/1ns
`include "fllcc_defs.svh"
module tb
    import fllcc_pkg::*;
;
    logic        clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, seed = 32'h277f;
    logic        pready, pslverr, err, osc_init = 0, stop = 0, dbg = 0, ext_run = 1;
    logic        sys, gi, ge, gi_q = 0, ge_q = 0, sy_q = 0, rs;
    logic        bu, ln, fi, rl, bu_q = 0, ln_q = 0, fi_q = 0;
    logic [3:0]  cnt_q = 0;
    logic [1:0]  src, prev;
    logic [7:0]  v;
    fllcc_mode_t em;
    int          fails = 0, n_checks = 0, n_gi = 0, n_ge = 0, n_sy = 0, a, b, c;
    int          n_bu = 0, n_ln = 0, n_fi = 0, n_rl = 0;

    always #5 clk_i = ~clk_i;
    // Slow references; ext can be frozen to model an absent source
    always @(posedge clk_i) cnt_q <= cnt_q + 4'h1;

    fllcc_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .int_ref_i(cnt_q[2]),
        .ext_ref_i(cnt_q[3] & ext_run), .fll_clk_i(cnt_q[1]), .osc_init_done_i(osc_init),
        .stop_i(stop), .debug_mode_active_i(dbg), .system_clock_out_o(sys), .bus_clock_o(bu),
        .debug_link_clock_o(ln), .gated_internal_reference_o(gi), .gated_external_reference_o(ge),
        .fll_enable_o(), .fll_reference_select_o(), .fll_filter_clock_o(fi),
        .fll_multiplier_o(), .fll_relock_o(rl), .int_ref_enable_o(), .ext_ref_enable_o(),
        .osc_range_o(), .osc_high_gain_o(), .coarse_trim_o(), .fine_trim_o(),
        .clock_mode_o());

    // Rising edge counters of the clock outputs
    always @(posedge clk_i) begin
        gi_q <= gi;
        ge_q <= ge;
        sy_q <= sys;
        if (gi & !gi_q) n_gi++;
        if (ge & !ge_q) n_ge++;
        if (sys & !sy_q) n_sy++;
        bu_q <= bu;
        ln_q <= ln;
        fi_q <= fi;
        if (bu & !bu_q) n_bu++;
        if (ln & !ln_q) n_ln++;
        if (fi & !fi_q) n_fi++;
        if (rl) n_rl++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic fllcc_mode_t exp_mode(input logic [1:0] s, input logic f, lp, d);
        case (s)
            2'h1: return (lp & !d) ? FLLCC_MODE_INT_BYPASS_LP : FLLCC_MODE_INT_BYPASS;
            2'h2: return (lp & !d) ? FLLCC_MODE_EXT_BYPASS_LP : FLLCC_MODE_EXT_BYPASS;
            default: return f ? FLLCC_MODE_INT_ENGAGED : FLLCC_MODE_EXT_ENGAGED;
        endcase
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    // Setup then access; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        r = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs a few thousand cycles
    initial begin
        #200000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1;
        apb(0, `FLLCC_CTRL1_OFS, 0); chk(r, 32'h04);
        apb(0, `FLLCC_CTRL2_OFS, 0); chk(r, 32'h40);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[3:2], 2'h0);
        chk(i_dut.clock_mode_o, FLLCC_MODE_INT_ENGAGED);
        chk(i_dut.fll_multiplier_o, 10'd512);
        apb(0, 12'h010, 0); chk(err, 1'b1); chk(r, 32'h0);
        // Trim survives a mid-run reset; reserved status bits read zero
        seed = lfsr(seed); v = seed[7:0];
        apb(1, `FLLCC_TRIM_OFS, {24'h0, v}); apb(1, `FLLCC_STATUS_OFS, 32'h01);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[7:4], 4'h0);
        chk(i_dut.fine_trim_o, 1'b1);
        reset_n_i <= 0; wt(2); reset_n_i <= 1;
        apb(0, `FLLCC_TRIM_OFS, 0); chk(r, {24'h0, v});
        chk(i_dut.coarse_trim_o, v);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[0], 1'b1);
        // Every source code with low power and debug combinations
        prev = 2'h0;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed); src = i[3:2];
            rs = (src == 2'h1) ? 1'b1 : (src == 2'h2) ? 1'b0 : seed[0];
            dbg <= i[0];
            apb(1, `FLLCC_CTRL2_OFS, 32'h40 | (i[1] << 3));
            apb(1, `FLLCC_CTRL1_OFS, {24'h0, src, 3'h0, rs, 2'h0});
            apb(0, `FLLCC_STATUS_OFS, 0); chk(r[3:2], prev);
            wt(80); prev = (src == 2'h3) ? 2'h0 : src;
            apb(0, `FLLCC_STATUS_OFS, 0); chk(r[3:2], prev);
            em = exp_mode(src, rs, i[1], i[0]);
            chk(i_dut.clock_mode_o, em);
            chk(i_dut.fll_enable_o, em != FLLCC_MODE_INT_BYPASS_LP &&
                em != FLLCC_MODE_EXT_BYPASS_LP);
            chk(i_dut.int_ref_enable_o, rs);
            chk(i_dut.ext_ref_enable_o, !rs);
            chk(i_dut.fll_reference_select_o, rs);
            // Link clock only where the FLL keeps running
            a = n_ln; wt(16);
            chk(n_ln != a, em != FLLCC_MODE_INT_BYPASS_LP &&
                em != FLLCC_MODE_EXT_BYPASS_LP);
        end
        // Absent source keeps the previous clock
        dbg <= 0; apb(1, `FLLCC_CTRL2_OFS, 32'h40); apb(1, `FLLCC_CTRL1_OFS, 32'h04); wt(80);
        ext_run <= 0; apb(1, `FLLCC_CTRL1_OFS, 32'h80); wt(80);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[3:2], 2'h0);
        ext_run <= 1; wt(80);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[3:2], 2'h2);
        // Oscillator ready is sticky until the enable is cleared
        apb(1, `FLLCC_CTRL1_OFS, 32'h04); wt(80); osc_init <= 1;
        apb(1, `FLLCC_CTRL2_OFS, 32'h46); wt(2); osc_init <= 0;
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[1], 1'b1);
        apb(1, `FLLCC_CTRL2_OFS, 32'h44);
        apb(0, `FLLCC_STATUS_OFS, 0); chk(r[1], 1'b0);
        // One relock per reference change; divider and filter rates follow their codes
        a = n_rl; apb(1, `FLLCC_CTRL1_OFS, 32'h00); wt(80);
        chk(n_rl - a, 1);
        apb(1, `FLLCC_CTRL1_OFS, 32'h04); wt(80);
        chk(n_rl - a, 2);
        for (int k = 0; k < 4; k++) begin
            apb(1, `FLLCC_CTRL2_OFS, {24'h0, k[1:0], 6'h0});
            apb(1, `FLLCC_CTRL1_OFS, {24'h0, 2'h0, k[2:0], 3'h4});
            wt(4); a = n_bu; b = n_sy; c = n_fi; wt(128);
            chk(n_sy - b, 32);
            chk(n_bu - a, 32 >> k);
            chk(n_fi - c, 16 >> k);
        end
        // Stop: only references with both enables keep running
        apb(1, `FLLCC_CTRL1_OFS, 32'h07); apb(1, `FLLCC_CTRL2_OFS, 32'h43); stop <= 1; wt(4);
        a = n_gi; b = n_ge; c = n_sy; wt(64);
        chk(n_gi != a, 1'b1);
        chk(n_ge != b, 1'b1);
        chk(n_sy != c, 1'b0);
        apb(1, `FLLCC_CTRL1_OFS, 32'h06); apb(1, `FLLCC_CTRL2_OFS, 32'h42); wt(4);
        a = n_gi; b = n_ge; wt(64);
        chk(n_gi != a, 1'b0);
        chk(n_ge != b, 1'b0);
        stop <= 0; wt(2);
        complete_run();
    end
endmodule // tb
